// File: logic/plp_pkg.sv
// Purpose: Shared constants and types for the PHY link profile core
// Assumes: 250 MHz system clock, clause 22 management frames
// Notes: Extended registers are reached through an address/data pair
package plp_pkg;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ = 250;
   localparam int FAST_DROP_US = 10;
   localparam logic [15:0] FAST_DROP_CYC = 16'(FAST_DROP_US * CLK_MHZ);
   localparam int MDIX_SLOT_US = 8;
   localparam logic [15:0] MDIX_SLOT_CYC = 16'(MDIX_SLOT_US * CLK_MHZ);
   localparam int LOSS_SLOW_US = 100;
   localparam logic [15:0] LOSS_SLOW_DEF = 16'(LOSS_SLOW_US * CLK_MHZ);
   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [15:0] REG_ADV = 16'h0004;
   localparam logic [15:0] REG_XCTL = 16'h000d;
   localparam logic [15:0] REG_XDATA = 16'h000e;
   localparam logic [15:0] REG_CTL = 16'h0019;
   localparam logic [15:0] REG_LED_MAIN = 16'h0025;
   localparam logic [15:0] REG_LED_PIN = 16'h0303;
   localparam logic [15:0] REG_LED_GLB = 16'h0460;
   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [15:0] ADV_RST = 16'h0141;
   localparam logic [15:0] CTL_RST = 16'h8001;
   localparam logic [15:0] LED_MAIN_RST = 16'h0000;
   localparam logic [15:0] LED_PIN_RST = 16'h0000;
   localparam logic [15:0] LED_GLB_RST = 16'h0001;
   localparam logic LED_OFF_RST = 1'h1;
   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int ADV_100FD = 8;
   localparam int ADV_10FD = 6;
   localparam int CTL_AUTO = 15;
   localparam int CTL_FORCE = 14;
   localparam int CTL_EEE = 1;
   localparam int CTL_FAST = 0;
   localparam int LED_POL = 0;
   localparam int LED_ANY = 0;
   localparam int LED_EN = 0;
   // ---------------------------------------------------------------
   // Management frame
   // ---------------------------------------------------------------
   localparam logic [4:0] PHY_ADDR = 5'h01;
   localparam logic [4:0] MD_HDR_END = 5'h0b;
   localparam logic [4:0] MD_TA = 5'h0c;
   localparam logic [4:0] MD_END = 5'h1d;
   localparam logic [1:0] OP_RD = 2'h2;
   localparam logic [1:0] OP_WR = 2'h1;
   // ---------------------------------------------------------------
   // States
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      LS_OFF = 4'h1,
      LS_SEEK = 4'h2,
      LS_ANEG = 4'h4,
      LS_UP = 4'h8
   } plp_ls_t;
   typedef enum logic [1:0] {
      MD_IDLE = 2'h1,
      MD_FRAME = 2'h2
   } plp_md_t;
endpackage

// File: logic/plp_core.sv
// Purpose: Link, management and data path core of a 10/100 PHY
// Assumes: Line receive inputs and MAC data are on link_clk_i; line_sig_i and line_abil_i are synchronised to clk_i
// Notes: Link state runs on clk_i, data path on link_clk_i
//
// Behaviour
// RULE1 - Link bring-up follows the 100BASE-TX state flow.
// RULE2 - Full-duplex 100 Mbit/s links are negotiated and run.
// RULE3 - Full-duplex 10 Mbit/s is a fallback link mode.
// RULE4 - Data path is MII, or RMII dibits when strapped.
// RULE5 - Auto-negotiation runs, its enable taken from a strap.
// RULE6 - Registers reached over MDC/MDIO; MDC at most 24 MHz.
// RULE7 - Pair crossover hunts automatically while no signal.
// RULE8 - Link output changes under 15 us after signal loss.
// RULE9 - Fast drop watches the line 10 us before declaring loss.
// RULE10 - Preamble nibbles pass through untouched.
// RULE11 - Low-power idle is off at reset; controller keeps it off.
// RULE12 - Receive error reaches the MAC in both MII and RMII.
// RULE13 - LED shows 100 Mbit/s full duplex, polarity selectable.
// RULE14 - Controller in reset keeps the PHY disabled.
// RULE15 - Controller samples link status about every 10 us.
// RULE16 - Defaults and straps suffice without management traffic.
// RULE17 - LED drops with loss, returns only on full link.
`timescale 1ns/1ps
module plp_core
   import plp_pkg::*;
#(
   parameter logic [15:0] LOSS_SLOW_CYC = LOSS_SLOW_DEF
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic link_clk_i,
   input wire logic phy_en_i,
   input wire logic strap_aneg_i,
   input wire logic strap_rmii_i,
   input wire logic mdc_i,
   input wire logic mdio_i,
   output logic mdio_o,
   output logic mdio_oe_o,
   input wire logic line_sig_i,
   input wire logic [1:0] line_abil_i,
   output logic mdix_o,
   output logic link_up_o,
   output logic led_o,
   input wire logic line_rx_dv_i,
   input wire logic [3:0] line_rxd_i,
   input wire logic line_rx_er_i,
   output logic mac_rx_dv_o,
   output logic [3:0] mac_rxd_o,
   output logic mac_rx_er_o,
   input wire logic mac_tx_en_i,
   input wire logic [3:0] mac_txd_i,
   output logic line_tx_en_o,
   output logic [3:0] line_txd_o
);
   logic [7:0] pin_s1_q, pin_s2_q;
   logic en_s, aneg_s, rmii_s, mdc_s, mdio_s, sig_s;
   logic [1:0] abil_s;
   logic mdc_d_q, mdc_rise;
   logic [1:0] strap_cnt_q;
   logic strap_ok_q, aneg_en_q, rmii_q;
   plp_md_t md_q;
   logic [4:0] md_cnt_q, md_reg_q;
   logic [15:0] md_sh_q, md_out_q, md_tgt, md_wdat, rd_data;
   logic md_rd_q, md_wr_q, md_wr_stb;
   logic [15:0] adv_q, ctl_q, led_main_q, led_pin_q, led_glb_q;
   logic [15:0] xctl_q, xaddr_q, lim;
   plp_ls_t ls_q, ls_d;
   logic [15:0] tmr_q, tmr_d;
   logic mdix_d, spd_q, spd_d, link_up_q, led_on;
   logic [1:0] common;
   logic [1:0] lk_s1_q, lk_s2_q;
   logic lk_up, lk_rmii, rx_dv_p_q, rx_open_q, rx_go;
   logic tx_en_p_q, tx_open_q, tx_go;

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pin_s1_q <= 8'h00;
         pin_s2_q <= 8'h00;
         mdc_d_q <= 1'b0;
      end else begin
         pin_s1_q <= {phy_en_i, strap_aneg_i, strap_rmii_i, mdc_i,
                      mdio_i, line_sig_i, line_abil_i};
         pin_s2_q <= pin_s1_q;
         mdc_d_q <= mdc_s;
      end
   end
   assign {en_s, aneg_s, rmii_s, mdc_s, mdio_s, sig_s} = pin_s2_q[7:2];
   assign abil_s = pin_s2_q[1:0];
   // Wide sampling keeps a 24 MHz MDC well resolved
   assign mdc_rise = mdc_s & ~mdc_d_q; // RULE6

   // ---------------------------------------------------------------
   // Strap capture
   // ---------------------------------------------------------------
   // Waits out the synchroniser before latching the straps
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         strap_cnt_q <= 2'h0;
         strap_ok_q <= 1'b0;
         aneg_en_q <= 1'b0;
         rmii_q <= 1'b0;
      end else if (!strap_ok_q) begin
         strap_cnt_q <= strap_cnt_q + 2'h1;
         if (strap_cnt_q == 2'h3) begin
            strap_ok_q <= 1'b1;
            aneg_en_q <= aneg_s; // RULE5 RULE16
            rmii_q <= rmii_s; // RULE4
         end
      end
   end

   // ---------------------------------------------------------------
   // Management frame engine
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         md_q <= MD_IDLE;
         md_cnt_q <= 5'h00;
         md_sh_q <= 16'h0000;
         md_reg_q <= 5'h00;
         md_rd_q <= 1'b0;
         md_wr_q <= 1'b0;
         md_out_q <= 16'h0000;
         mdio_o <= 1'b0;
         mdio_oe_o <= 1'b0;
      end else if (mdc_rise) begin
         md_sh_q <= {md_sh_q[14:0], mdio_s};
         case (md_q)
            MD_IDLE: begin
               if (md_sh_q[1:0] == 2'h2 && mdio_s) begin // RULE6
                  md_q <= MD_FRAME;
                  md_cnt_q <= 5'h00;
               end
            end
            MD_FRAME: begin
               md_cnt_q <= md_cnt_q + 5'h01;
               if (md_cnt_q == MD_HDR_END) begin
                  md_reg_q <= {md_sh_q[3:0], mdio_s};
                  md_rd_q <= md_sh_q[10:9] == OP_RD &&
                             md_sh_q[8:4] == PHY_ADDR;
                  md_wr_q <= md_sh_q[10:9] == OP_WR &&
                             md_sh_q[8:4] == PHY_ADDR;
               end
               if (md_cnt_q == MD_TA && md_rd_q) begin
                  mdio_oe_o <= 1'b1;
                  mdio_o <= 1'b0;
                  md_out_q <= rd_data;
               end else if (md_cnt_q > MD_TA && md_cnt_q < MD_END &&
                            md_rd_q) begin
                  mdio_o <= md_out_q[15];
                  md_out_q <= {md_out_q[14:0], 1'b0};
               end
               if (md_cnt_q == MD_END) begin
                  md_q <= MD_IDLE;
                  md_sh_q <= 16'h0000;
                  md_rd_q <= 1'b0;
                  md_wr_q <= 1'b0;
                  mdio_o <= 1'b0;
                  mdio_oe_o <= 1'b0;
               end
            end
            default: md_q <= MD_IDLE;
         endcase
      end
   end
   assign md_wr_stb = mdc_rise && md_q == MD_FRAME &&
                      md_cnt_q == MD_END && md_wr_q;
   assign md_wdat = {md_sh_q[14:0], mdio_s};
   // Data port of the pair falls through to the extended address
   assign md_tgt = (md_reg_q == REG_XDATA[4:0] && xctl_q[15:14] != 2'h0)
                   ? xaddr_q : {11'h000, md_reg_q};

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         adv_q <= ADV_RST; // RULE2 RULE3
         ctl_q <= CTL_RST; // RULE11 RULE16
         led_main_q <= LED_MAIN_RST;
         led_pin_q <= LED_PIN_RST;
         led_glb_q <= LED_GLB_RST;
         xctl_q <= 16'h0000;
         xaddr_q <= 16'h0000;
      end else if (md_wr_stb) begin
         if (md_tgt == REG_ADV) begin
            adv_q <= md_wdat;
         end else if (md_tgt == REG_CTL) begin
            ctl_q <= md_wdat;
         end else if (md_tgt == REG_LED_MAIN) begin
            led_main_q <= md_wdat;
         end else if (md_tgt == REG_LED_PIN) begin
            led_pin_q <= md_wdat;
         end else if (md_tgt == REG_LED_GLB) begin
            led_glb_q <= md_wdat;
         end else if (md_tgt == REG_XCTL) begin
            xctl_q <= md_wdat;
         end else if (md_tgt == REG_XDATA) begin
            xaddr_q <= md_wdat;
         end
      end
   end

   always_comb begin
      if (md_tgt == REG_ADV) begin
         rd_data = adv_q;
      end else if (md_tgt == REG_CTL) begin
         // Live status bits let the controller poll the link
         rd_data = {ctl_q[15:5], link_up_q, spd_q, mdix_o,
                    ctl_q[1:0]}; // RULE15
      end else if (md_tgt == REG_LED_MAIN) begin
         rd_data = led_main_q;
      end else if (md_tgt == REG_LED_PIN) begin
         rd_data = led_pin_q;
      end else if (md_tgt == REG_LED_GLB) begin
         rd_data = led_glb_q;
      end else if (md_tgt == REG_XCTL) begin
         rd_data = xctl_q;
      end else if (md_tgt == REG_XDATA) begin
         rd_data = xaddr_q;
      end else begin
         rd_data = 16'h0000;
      end
   end

   // ---------------------------------------------------------------
   // Link state
   // ---------------------------------------------------------------
   assign common = {adv_q[ADV_100FD], adv_q[ADV_10FD]} & abil_s;
   assign lim = ctl_q[CTL_FAST] ? FAST_DROP_CYC : LOSS_SLOW_CYC; // RULE9

   always_comb begin
      ls_d = ls_q;
      tmr_d = tmr_q;
      mdix_d = mdix_o;
      spd_d = spd_q;
      case (ls_q)
         LS_OFF: begin
            if (strap_ok_q) begin
               ls_d = LS_SEEK;
            end
         end
         LS_SEEK: begin
            if (sig_s) begin
               ls_d = LS_ANEG;
               tmr_d = 16'h0000;
            end else if (tmr_q == MDIX_SLOT_CYC - 16'h0001) begin
               tmr_d = 16'h0000;
               mdix_d = ~mdix_o; // RULE7
            end else begin
               tmr_d = tmr_q + 16'h0001;
            end
         end
         LS_ANEG: begin
            if (!sig_s) begin
               ls_d = LS_SEEK; // RULE1
            end else if (!aneg_en_q) begin
               ls_d = LS_UP;
               spd_d = 1'b1;
            end else if (common[1]) begin
               ls_d = LS_UP; // RULE5
               spd_d = 1'b1; // RULE2
            end else if (common[0]) begin
               ls_d = LS_UP;
               spd_d = 1'b0; // RULE3
            end
         end
         LS_UP: begin
            if (sig_s) begin
               tmr_d = 16'h0000;
            end else if (tmr_q >= lim - 16'h0001) begin
               ls_d = LS_SEEK; // RULE8 RULE9
               tmr_d = 16'h0000;
            end else begin
               tmr_d = tmr_q + 16'h0001;
            end
         end
         default: ls_d = LS_OFF;
      endcase
      if (!ctl_q[CTL_AUTO]) begin
         mdix_d = ctl_q[CTL_FORCE];
      end
      if (!en_s) begin
         ls_d = LS_OFF; // RULE14
         tmr_d = 16'h0000;
      end
   end

   // LED follows the next state so it drops on the same edge
   assign led_on = ls_d == LS_UP && led_glb_q[LED_EN] &&
                   (spd_d || led_pin_q[LED_ANY]); // RULE13 RULE17

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ls_q <= LS_OFF;
         tmr_q <= 16'h0000;
         mdix_o <= 1'b0;
         spd_q <= 1'b0;
         link_up_q <= 1'b0;
         led_o <= LED_OFF_RST;
      end else begin
         ls_q <= ls_d;
         tmr_q <= tmr_d;
         mdix_o <= mdix_d;
         spd_q <= spd_d;
         link_up_q <= ls_d == LS_UP; // RULE17
         led_o <= led_main_q[LED_POL] ? led_on : ~led_on; // RULE13
      end
   end
   assign link_up_o = link_up_q;

   // ---------------------------------------------------------------
   // Data path on the link clock
   // ---------------------------------------------------------------
   always_ff @(posedge link_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lk_s1_q <= 2'h0;
         lk_s2_q <= 2'h0;
      end else begin
         lk_s1_q <= {link_up_q, rmii_q};
         lk_s2_q <= lk_s1_q;
      end
   end
   assign {lk_up, lk_rmii} = lk_s2_q;

   // Gate opens only at frame start, so no frame is ever cut short
   assign rx_go = line_rx_dv_i && (rx_dv_p_q ? rx_open_q : lk_up);
   assign tx_go = mac_tx_en_i && (tx_en_p_q ? tx_open_q : lk_up);

   always_ff @(posedge link_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_dv_p_q <= 1'b0;
         rx_open_q <= 1'b0;
         mac_rx_dv_o <= 1'b0;
         mac_rxd_o <= 4'h0;
         mac_rx_er_o <= 1'b0;
      end else begin
         rx_dv_p_q <= line_rx_dv_i;
         rx_open_q <= rx_go;
         mac_rx_dv_o <= rx_go; // RULE10
         if (!rx_go) begin
            mac_rxd_o <= 4'h0;
         end else if (lk_rmii) begin
            mac_rxd_o <= {2'h0, line_rxd_i[1:0]}; // RULE4
         end else begin
            mac_rxd_o <= line_rxd_i; // RULE10
         end
         mac_rx_er_o <= rx_go && line_rx_er_i; // RULE12
      end
   end

   always_ff @(posedge link_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tx_en_p_q <= 1'b0;
         tx_open_q <= 1'b0;
         line_tx_en_o <= 1'b0;
         line_txd_o <= 4'h0;
      end else begin
         tx_en_p_q <= mac_tx_en_i;
         tx_open_q <= tx_go;
         line_tx_en_o <= tx_go;
         line_txd_o <= tx_go ? mac_txd_i : 4'h0; // RULE10
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   property p_led_drop;
      @(posedge clk_i) disable iff (!rst_n_i)
      $fell(link_up_q) |-> led_o == !led_main_q[LED_POL];
   endproperty
   a_led_drop: assert property (p_led_drop) // RULE17
      else $error("led did not drop with link");

   property p_fast_win;
      @(posedge clk_i) disable iff (!rst_n_i)
      ls_q == LS_UP && ls_d == LS_SEEK && en_s && ctl_q[CTL_FAST]
      |-> tmr_q == FAST_DROP_CYC - 16'h0001;
   endproperty
   a_fast_win: assert property (p_fast_win) // RULE9
      else $error("fast drop window length wrong");

   property p_fast_max;
      @(posedge clk_i) disable iff (!rst_n_i)
      ls_q == LS_UP && ctl_q[CTL_FAST] |-> tmr_q < FAST_DROP_CYC;
   endproperty
   a_fast_max: assert property (p_fast_max) // RULE8
      else $error("loss counter ran past window");

   property p_eee_off;
      @(posedge clk_i) disable iff (!rst_n_i)
      $rose(ctl_q[CTL_EEE]) |-> $past(md_wr_stb);
   endproperty
   a_eee_off: assert property (p_eee_off) // RULE11
      else $error("idle power mode set without write");

   property p_phy_off;
      @(posedge clk_i) disable iff (!rst_n_i)
      !en_s |=> ls_q == LS_OFF && !link_up_q;
   endproperty
   a_phy_off: assert property (p_phy_off) // RULE14
      else $error("link formed while disabled");

   property p_mdix_hold;
      @(posedge clk_i) disable iff (!rst_n_i)
      ls_q == LS_UP && ctl_q[CTL_AUTO] |=> $stable(mdix_o);
   endproperty
   a_mdix_hold: assert property (p_mdix_hold) // RULE7
      else $error("crossover moved during link");

   property p_md_ta;
      @(posedge clk_i) disable iff (!rst_n_i)
      md_q == MD_FRAME && mdc_rise && md_cnt_q == MD_TA && md_rd_q
      |=> mdio_oe_o && !mdio_o;
   endproperty
   a_md_ta: assert property (p_md_ta) // RULE6
      else $error("turnaround zero not driven");

   property p_rx_pass;
      @(posedge link_clk_i) disable iff (!rst_n_i)
      rx_go |=> mac_rx_dv_o &&
      mac_rxd_o[1:0] == $past(line_rxd_i[1:0]);
   endproperty
   a_rx_pass: assert property (p_rx_pass) // RULE10
      else $error("receive nibble altered");

   property p_rx_er;
      @(posedge link_clk_i) disable iff (!rst_n_i)
      mac_rx_er_o |-> mac_rx_dv_o && $past(line_rx_er_i);
   endproperty
   a_rx_er: assert property (p_rx_er) // RULE12
      else $error("receive error without cause");
endmodule

// File: dv/plp_ctl_model.sv
// Purpose: Controller model that drives management frames
// Assumes: MDC period of 12 clk_i cycles, pull-up on the data wire
// Notes: Read bits sampled just before each MDC rise
`timescale 1ns/1ps
module plp_ctl_model
   import plp_pkg::*;
(
   input wire logic clk_i,
   input wire logic mdio_i,
   output logic mdc_o,
   output logic mdio_o,
   output logic mdio_oe_o
);
   initial begin
      mdc_o = 1'b0;
      mdio_o = 1'b1;
      mdio_oe_o = 1'b0;
   end
   // Wire released in TA and data of reads; MDC idles low
   task automatic frame(input logic [1:0] op, input logic [4:0] pa,
         input logic [4:0] ra, input logic [15:0] wd,
         output logic [15:0] rdat);
      logic [63:0] f;
      f = {32'hffff_ffff, 2'h1, op, pa, ra, 2'h2, wd};
      for (int i = 63; i >= 0; i--) begin
         mdio_oe_o = !(op == OP_RD && i < 18);
         mdio_o = f[i];
         repeat (6) @(posedge clk_i);
         #1;
         if (i < 16) rdat[i] = mdio_i;
         mdc_o = 1'b1;
         repeat (6) @(posedge clk_i);
         #1;
         mdc_o = 1'b0;
      end
      mdio_oe_o = 1'b0;
      // Idle gap so a following frame never re-drives in this step
      repeat (2) @(posedge clk_i);
      #1;
   endtask
endmodule

// File: dv/tb.sv
// Purpose: Self-checking bench for the PHY link profile core
// Assumes: 250 MHz clk, 15 ns link clock, pulled-up mdio wire
// Notes: Slow loss count cut to 5000 cycles to keep the run short
`timescale 1ns/1ps
module tb;
   import plp_pkg::*;
   localparam logic [15:0] SLOW = 16'h1388;
   logic clk = 1'b0;
   logic lclk = 1'b0;
   logic rst_n, en, s_an, s_rm, mdc, mdio, d_mdio, d_oe, c_mdio, c_oe;
   logic sig, mdix, up, led, rdv, rer, mdv, mer, ten, lten, gate, chk;
   logic [1:0] abil;
   logic [3:0] rxd, mrxd, txd, ltxd;
   logic [5:0] erx_q, etx_q;
   logic [15:0] r;
   int error_cnt = 0;
   int total_checks = 0;
   int seed = 84409;
   int n;
   // ---------------------------------------------------------------
   // Clocks and wiring
   // ---------------------------------------------------------------
   always #2 clk = ~clk;
   always #7.5 lclk = ~lclk;
   assign mdio = d_oe ? d_mdio : (c_oe ? c_mdio : 1'b1);
   plp_core #(.LOSS_SLOW_CYC(SLOW)) dut (
      .clk_i(clk), .rst_n_i(rst_n), .link_clk_i(lclk), .phy_en_i(en),
      .strap_aneg_i(s_an), .strap_rmii_i(s_rm), .mdc_i(mdc),
      .mdio_i(mdio), .mdio_o(d_mdio), .mdio_oe_o(d_oe),
      .line_sig_i(sig), .line_abil_i(abil), .mdix_o(mdix),
      .link_up_o(up), .led_o(led), .line_rx_dv_i(rdv),
      .line_rxd_i(rxd), .line_rx_er_i(rer), .mac_rx_dv_o(mdv),
      .mac_rxd_o(mrxd), .mac_rx_er_o(mer), .mac_tx_en_i(ten),
      .mac_txd_i(txd), .line_tx_en_o(lten), .line_txd_o(ltxd));
   plp_ctl_model u_ctl (.clk_i(clk), .mdio_i(mdio), .mdc_o(mdc),
      .mdio_o(c_mdio), .mdio_oe_o(c_oe));
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [5:0] exp_nib(input logic dv, input logic er,
         input logic [3:0] d);
      return (gate && dv) ? {1'b1, er, d} : 6'h00;
   endfunction
   function automatic logic [3:0] nib(input int i);
      logic [3:0] v;
      v = (i < 15) ? 4'h5 : (i == 15) ? 4'hd : 4'($random(seed));
      return s_rm ? (v & 4'h3) : v;
   endfunction
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         error_cnt++;
      end
   endtask
   task automatic stop_test();
      $display("checks=%0d errors=%0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic do_reset(input logic an, input logic rm);
      rst_n = 1'b0;
      en = 1'b0;
      s_an = an;
      s_rm = rm;
      tick(12);
      rst_n = 1'b1;
      tick(8);
   endtask
   // Wide offsets go through the address/data pair, reads and writes
   task automatic sel(inout logic [15:0] ra);
      logic [15:0] x;
      if (ra > 16'h001f) begin
         u_ctl.frame(OP_WR, PHY_ADDR, REG_XCTL[4:0], 16'h0000, x);
         u_ctl.frame(OP_WR, PHY_ADDR, REG_XDATA[4:0], ra, x);
         u_ctl.frame(OP_WR, PHY_ADDR, REG_XCTL[4:0], 16'h4000, x);
         ra = REG_XDATA;
      end
   endtask
   task automatic wr(input logic [15:0] ra, input logic [15:0] d);
      logic [15:0] x;
      sel(ra);
      u_ctl.frame(OP_WR, PHY_ADDR, ra[4:0], d, x);
   endtask
   task automatic rdc(input logic [15:0] ra, input logic [15:0] m,
         input logic [15:0] e);
      sel(ra);
      u_ctl.frame(OP_RD, PHY_ADDR, ra[4:0], 16'h0000, r);
      check(r & m, e);
   endtask
   task automatic link_on(input logic [1:0] ab);
      abil = ab;
      sig = 1'b1;
      for (int i = 0; i < 100 && up !== 1'b1; i++) tick(1);
      check(16'(up), 16'h0001);
   endtask
   task automatic drop(input int lim);
      sig = 1'b0;
      n = 0;
      while (up !== 1'b0 && n < lim + 20) begin
         tick(1);
         n++;
      end
      check(16'(n >= lim && n <= lim + 10), 16'h0001);
   endtask
   task automatic pkt(input logic open);
      int len;
      len = 40 + ($random(seed) & 15);
      gate = open;
      @(posedge lclk);
      #1;
      chk = 1'b1;
      for (int i = 0; i < len; i++) begin
         {rdv, ten, rer} = {2'h3, i == len - 5};
         rxd = nib(i);
         txd = nib(i);
         @(posedge lclk);
         #1;
      end
      {rdv, rer, ten, rxd, txd} = '0;
      repeat (4) @(posedge lclk);
      #1;
      chk = 1'b0;
   endtask
   // Compare at the falling edge, away from both launch points
   always @(posedge lclk) begin
      erx_q <= exp_nib(rdv, rer, rxd);
      etx_q <= exp_nib(ten, 1'b0, txd);
   end
   always @(negedge lclk) begin
      if (chk) begin
         check(16'({mdv, mer, mrxd}), 16'(erx_q));
         check(16'({lten, 1'b0, ltxd}), 16'(etx_q));
      end
   end
   initial begin
      #380000;
      error_cnt++;
      stop_test();
   end
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      {rst_n, en, sig, chk, gate, rdv, rer, ten, rxd, txd} = '0;
      {s_an, s_rm, abil} = 4'h b;
      do_reset(1'b1, 1'b0);
      check(16'(led), 16'(LED_OFF_RST));
      rdc(REG_ADV, 16'hffff, ADV_RST);
      rdc(REG_CTL, 16'hffe3, CTL_RST);
      rdc(REG_LED_MAIN, 16'hffff, LED_MAIN_RST);
      rdc(REG_LED_PIN, 16'hffff, LED_PIN_RST);
      rdc(REG_LED_GLB, 16'hffff, LED_GLB_RST);
      rdc(16'h001f, 16'hffff, 16'h0000);
      u_ctl.frame(OP_RD, PHY_ADDR + 5'h01, 5'h04, 16'h0000, r);
      check(r, 16'hffff);
      sig = 1'b1;
      pkt(1'b0);
      for (int i = 0; i < 2; i++) begin
         rdc(REG_CTL, 16'h0010, 16'h0000);
         tick(1732);
      end
      {sig, en, n} = {2'h1, 32'h0};
      for (int i = 0; i < 4100; i++) begin
         r[0] = mdix;
         tick(1);
         n += int'(mdix !== r[0]);
      end
      check(16'(n), 16'h0002);
      link_on(2'h3);
      check(16'(led), 16'h0000);
      rdc(REG_CTL, 16'h0018, 16'h0018);
      pkt(1'b1);
      // Dropout shorter than the window keeps the link
      sig = 1'b0;
      tick(500 + ($random(seed) & 1023));
      sig = 1'b1;
      tick(4);
      check(16'(up), 16'h0001);
      drop(2500);
      check(16'(n < 3750), 16'h0001);
      check(16'(led), 16'(LED_OFF_RST));
      link_on(2'h1);
      check(16'(led), 16'(LED_OFF_RST));
      rdc(REG_CTL, 16'h0018, 16'h0010);
      drop(2500);
      wr(REG_LED_MAIN, 16'h0001);
      link_on(2'h3);
      check(16'(led), 16'h0001);
      wr(REG_CTL, 16'h8000);
      drop(int'(SLOW));
      do_reset(1'b0, 1'b1);
      en = 1'b1;
      link_on(2'h1);
      rdc(REG_CTL, 16'h0018, 16'h0018);
      pkt(1'b1);
      stop_test();
   end
endmodule
